//--- design/ddr_edc_path.sv
// Error correction path between the word buffer and external DDR memory
`timescale 1ns/100ps
`default_nettype none
`include "ddr_edc_consts.svh"
module ddr_edc_path
	import ddr_edc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [2:0]  mem_iface_cfg,
	input  wire logic        mem_clock_speed_sel,
	input  wire logic        mem_clk,
	input  wire logic [63:0] wr_data,
	input  wire logic        wr_valid,
	output logic             wr_ready,
	input  wire logic        rd_req,
	output logic [63:0]      rd_data,
	output logic             rd_valid,
	output logic             err_fixed,
	input  wire logic [63:0] dq_in,
	output logic [63:0]      dq_out,
	output logic             dq_oe_n,
	output logic [7:0]       dqs_out,
	output logic             dqs_oe_n,
	output logic             error_correction,
	output logic             mem_clk_sel,
	output logic             cfg_locked,
	output logic [1:0]       arrangement
);
	edc_state_t s;
	edc_state_t n;

	// Write stream into the buffer and out towards memory
	stream_if #(.W(`DATA_W)) fill_bus ();
	stream_if #(.W(`DATA_W)) drain_bus ();

	logic        pop;
	logic        edge_seen;
	logic [1:0]  nbeats;
	logic [7:0]  lane_mask;
	logic [7:0]  wr_check;
	logic [7:0]  rd_check;
	logic [6:0]  syndrome;
	logic        parity_bad;
	logic [63:0] fixed_word;
	logic        single_err;
	logic        cfg_edc;
	logic [1:0]  cfg_arr;

	assign fill_bus.data = wr_data;
	assign fill_bus.valid = wr_valid;
	assign wr_ready = fill_bus.ready;
	assign drain_bus.ready = pop;

	stream_fifo #(
		.W     (`DATA_W),
		.DEPTH (`FIFO_DEPTH)
	) wr_buffer (
		.clock (clock),
		.rst_n (rst_n),
		.fill  (fill_bus),
		.drain (drain_bus)
	);

	// Check bits for the word leaving the buffer
	edc_check_gen wr_gen (
		.data  (drain_bus.data),
		.check (wr_check)
	);

	// Check bits recomputed over the word read back
	edc_check_gen rd_gen (
		.data  (s.rd_word),
		.check (rd_check)
	);

	// Configuration code decode: bit 1 enables, inverted for the wide pair
	always_comb begin
		cfg_edc = s.cfg_s2[1] ^ (s.cfg_s2[2] & s.cfg_s2[0]);
		cfg_arr = {s.cfg_s2[2], s.cfg_s2[0]};
	end

	// Strobe lanes in use, two strobes per 16-bit lane
	always_comb begin
		case (s.arr)
			ARR_X16: lane_mask = `LANES_X16;
			ARR_X32: lane_mask = `LANES_X32;
			ARR_X36: lane_mask = `LANES_X36;
			ARR_X64: lane_mask = `LANES_X64;
			default: lane_mask = `LANES_X32;
		endcase
	end

	// Beats per word: third beat only with correction on
	assign nbeats = s.edc_on ? `BEATS_EDC : `BEATS_PLAIN;

	// Rising memory clock edge seen past the synchroniser
	assign edge_seen = s.ck_s2 & ~s.ck_s3;

	// Syndrome and total parity of the word read back
	always_comb begin
		syndrome = rd_check[6:0] ^ s.rd_chk[6:0];
		parity_bad = ^{s.rd_word, s.rd_chk};
		single_err = parity_bad;
		fixed_word = s.rd_word;
		for (int i = 0; i < 64; i++) begin
			if (single_err && (data_position(i) == syndrome)) begin
				fixed_word[i] = ~s.rd_word[i];
			end
		end
	end

	// Buffer drained only when idle, configured and no read waiting
	assign pop = (s.st == ST_IDLE) && s.locked && !rd_req && drain_bus.valid;

	// Next state of the whole path
	always_comb begin
		n = s;
		n.rd_done = 1'b0;
		n.rd_valid = 1'b0;
		n.err_fixed = 1'b0;

		// Pin synchronisers
		n.cfg_s1 = mem_iface_cfg;
		n.cfg_s2 = s.cfg_s1;
		n.spd_s1 = mem_clock_speed_sel;
		n.spd_s2 = s.spd_s1;
		n.ck_s1 = mem_clk;
		n.ck_s2 = s.ck_s1;
		n.ck_s3 = s.ck_s2;
		n.dq_s1 = dq_in;
		n.dq_s2 = s.dq_s1;

		// Mode caught once after reset release, then frozen
		if (!s.locked) begin
			if (s.lock_cnt == `LOCK_CYC) begin
				n.locked = 1'b1;
				n.edc_on = cfg_edc;
				n.arr = arrangement_t'(cfg_arr);
				n.speed_hi = s.spd_s2;
			end else begin
				n.lock_cnt = s.lock_cnt + 2'h1;
			end
		end

		// Read result one cycle after the last beat is captured
		if (s.rd_done) begin
			n.rd_valid = 1'b1;
			if (s.edc_on) begin
				n.rd_data = fixed_word;
				n.err_fixed = single_err;
			end else begin
				n.rd_data = s.rd_word;
			end
		end

		case (s.st)
			ST_IDLE: begin
				n.beat = 2'h0;
				if (s.locked && rd_req) begin
					n.st = ST_READ;
				end else if (pop) begin
					n.st = ST_WRITE;
					n.word = drain_bus.data;
					n.chk = s.edc_on ? wr_check : 8'h00;
				end
			end
			ST_WRITE: begin
				if (edge_seen) begin
					if (s.beat < nbeats) begin
						n.dq_oe_n = 1'b0;
						n.dqs_oe_n = 1'b0;
						n.dqs_out = lane_mask;
						n.beat = s.beat + 2'h1;
						case (s.beat)
							2'h0: n.dq_out = {2{s.word[31:0]}};
							2'h1: n.dq_out = {2{s.word[63:32]}};
							// Check beat: upper 24 bits of the column wasted
							default: n.dq_out = {2{`UNUSED_W'(0), s.chk}};
						endcase
					end else begin
						n.dq_oe_n = 1'b1;
						n.dqs_oe_n = 1'b1;
						n.dqs_out = 8'h00;
						n.st = ST_IDLE;
					end
				end
			end
			ST_READ: begin
				if (edge_seen) begin
					case (s.beat)
						2'h0: n.rd_word[31:0] = s.dq_s2[31:0];
						2'h1: n.rd_word[63:32] = s.dq_s2[31:0];
						default: n.rd_chk = s.dq_s2[7:0];
					endcase
					n.beat = s.beat + 2'h1;
					if (s.beat == nbeats - 2'h1) begin
						n.rd_done = 1'b1;
						n.st = ST_IDLE;
					end
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
	end

	// State register, pins released at reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.dq_oe_n <= 1'b1;
			s.dqs_oe_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign rd_data = s.rd_data;
	assign rd_valid = s.rd_valid;
	assign err_fixed = s.err_fixed;
	assign dq_out = s.dq_out;
	assign dq_oe_n = s.dq_oe_n;
	assign dqs_out = s.dqs_out;
	assign dqs_oe_n = s.dqs_oe_n;
	assign error_correction = s.edc_on;
	assign mem_clk_sel = s.speed_hi;
	assign cfg_locked = s.locked;
	assign arrangement = s.arr;
endmodule
`default_nettype wire

//--- design/ddr_edc_consts.svh
// Constants for the external memory error correction path
`ifndef DDR_EDC_CONSTS_SVH
`define DDR_EDC_CONSTS_SVH
// Word and beat widths
`define DATA_W          64
`define CHK_W           8
`define BEAT_W          32
`define UNUSED_W        24
// Buffer depth
`define FIFO_DEPTH      32
// Beats per stored word
`define BEATS_PLAIN     2'h2
`define BEATS_EDC       2'h3
// Clock edges after reset release before configuration is captured
`define LOCK_CYC        2'h3
// Memory clock rates in MHz
`define MEM_CLK_SLOW_MHZ 133
`define MEM_CLK_FAST_MHZ 166
// Configuration codes, correction off and on
`define CFG_X32_OFF     3'h0
`define CFG_X32_ON      3'h2
`define CFG_X16_OFF     3'h1
`define CFG_X16_ON      3'h3
`define CFG_X64_OFF     3'h7
`define CFG_X64_ON      3'h5
`define CFG_X36_OFF     3'h4
`define CFG_X36_ON      3'h6
// Strobe lanes in use per arrangement
`define LANES_X16       8'h03
`define LANES_X32       8'h0F
`define LANES_X36       8'h3F
`define LANES_X64       8'hFF
`endif

//--- design/ddr_edc_pkg.sv
// Types and the code-position function of the memory error correction path
`default_nettype none
package ddr_edc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ  = 2'b10
	} mem_state_t;

	typedef enum logic [1:0] {
		ARR_X32 = 2'b00,
		ARR_X16 = 2'b01,
		ARR_X36 = 2'b10,
		ARR_X64 = 2'b11
	} arrangement_t;

	typedef struct packed {
		mem_state_t   st;
		logic [1:0]   beat;
		logic [63:0]  word;
		logic [7:0]   chk;
		logic [2:0]   cfg_s1;
		logic [2:0]   cfg_s2;
		logic         spd_s1;
		logic         spd_s2;
		logic [1:0]   lock_cnt;
		logic         locked;
		logic         edc_on;
		arrangement_t arr;
		logic         speed_hi;
		logic         ck_s1;
		logic         ck_s2;
		logic         ck_s3;
		logic [63:0]  dq_s1;
		logic [63:0]  dq_s2;
		logic [63:0]  dq_out;
		logic         dq_oe_n;
		logic [7:0]   dqs_out;
		logic         dqs_oe_n;
		logic [63:0]  rd_word;
		logic [7:0]   rd_chk;
		logic         rd_done;
		logic [63:0]  rd_data;
		logic         rd_valid;
		logic         err_fixed;
	} edc_state_t;

	// Codeword position of data bit idx, skipping power-of-two slots
	function automatic logic [6:0] data_position(input int idx);
		logic [6:0] pos;
		int         n;
		pos = '0;
		n = 0;
		for (int q = 3; q < 72; q++) begin
			if ((q & (q - 1)) != 0) begin
				if (n == idx) begin
					pos = 7'(q);
				end
				n++;
			end
		end
		return pos;
	endfunction
endpackage
`default_nettype wire

//--- design/stream_if.sv
// Valid and ready word stream between the path's own modules
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(parameter int W = 64);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

//--- design/stream_fifo.sv
// Word buffer in the write data path
`timescale 1ns/100ps
`default_nettype none
`include "ddr_edc_consts.svh"
module stream_fifo #(
	parameter int W     = `DATA_W,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic clock,
	input  wire logic rst_n,
	stream_if.snk     fill,
	stream_if.src     drain
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    rdy;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t n;
	logic        push;
	logic        pop;

	// Push and pop, ready falls when the last slot fills
	always_comb begin
		push = fill.valid && s.rdy;
		pop = drain.ready && (s.cnt != '0);
		n = s;
		if (push) begin
			n.mem[s.wp] = fill.data;
			n.wp = s.wp + 1'b1;
		end
		if (pop) begin
			n.rp = s.rp + 1'b1;
		end
		n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
		n.rdy = (n.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.rdy <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign fill.ready = s.rdy;
	assign drain.valid = (s.cnt != '0);
	assign drain.data = s.mem[s.rp];
endmodule
`default_nettype wire

//--- design/edc_check_gen.sv
// Eight check bits over one 64-bit word
`timescale 1ns/100ps
`default_nettype none
module edc_check_gen
	import ddr_edc_pkg::*;
(
	input  wire logic [63:0] data,
	output logic      [7:0]  check
);
	logic [6:0] pos;

	// Hamming bits by position, top bit makes total parity even
	always_comb begin
		check = '0;
		pos = '0;
		for (int i = 0; i < 64; i++) begin
			pos = data_position(i);
			for (int k = 0; k < 7; k++) begin
				if (pos[k]) begin
					check[k] = check[k] ^ data[i];
				end
			end
		end
		check[7] = ^{data, check[6:0]};
	end
endmodule
`default_nettype wire

//--- sim/edc_path_checker.sv
// Port assertions for the memory error correction path
`timescale 1ns/100ps
`default_nettype none
module edc_path_checker (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic [2:0] mem_iface_cfg,
	input wire logic       mem_clock_speed_sel,
	input wire logic       rd_valid,
	input wire logic       err_fixed,
	input wire logic       dq_oe_n,
	input wire logic [7:0] dqs_out,
	input wire logic       dqs_oe_n,
	input wire logic       error_correction,
	input wire logic       mem_clk_sel,
	input wire logic       cfg_locked,
	input wire logic [1:0] arrangement
);
	logic [7:0] run;
	logic [7:0] mask;
	logic       edc_exp;
	logic [1:0] arr_exp;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Cycles the data pins have been driven
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run <= 8'h00;
		end else begin
			run <= dq_oe_n ? 8'h00 : run + 8'h01;
		end
	end
	// Expected enable and arrangement for each code, then strobe lanes
	always_comb begin
		case (mem_iface_cfg)
			3'h2, 3'h3, 3'h5, 3'h6: edc_exp = 1'b1;
			default:                edc_exp = 1'b0;
		endcase
		case (mem_iface_cfg)
			3'h0, 3'h2: arr_exp = 2'h0;
			3'h1, 3'h3: arr_exp = 2'h1;
			3'h4, 3'h6: arr_exp = 2'h2;
			default:    arr_exp = 2'h3;
		endcase
		case (arrangement)
			2'h0: mask = 8'h0F;
			2'h1: mask = 8'h03;
			2'h2: mask = 8'h3F;
			default: mask = 8'hFF;
		endcase
	end
	strobe_lanes_a: assert property (!dqs_oe_n |-> dqs_out == mask)
		else $error("wrong strobe lanes");
	edc_decode_a: assert property (cfg_locked |-> error_correction == edc_exp)
		else $error("wrong correction enable");
	arr_decode_a: assert property (cfg_locked |-> arrangement == arr_exp)
		else $error("wrong arrangement");
	speed_sel_a: assert property (cfg_locked |-> mem_clk_sel == mem_clock_speed_sel)
		else $error("wrong speed select");
	cfg_hold_a: assert property (cfg_locked |=> cfg_locked && $stable({error_correction, arrangement, mem_clk_sel}))
		else $error("mode changed after capture");
	burst_len_a: assert property ($rose(dq_oe_n) |-> run == (error_correction ? 8'h18 : 8'h10))
		else $error("wrong beat count");
	rd_pulse_a: assert property (rd_valid |=> !rd_valid)
		else $error("read valid too long");
	fix_edc_a: assert property (err_fixed |-> rd_valid && error_correction)
		else $error("stray fix flag");
	idle_locked_a: assert property (!dq_oe_n |-> cfg_locked)
		else $error("traffic before capture");
	cover property ($rose(err_fixed));
	cover property ($rose(dq_oe_n) && error_correction);
	cover property (rd_valid && !error_correction);
endmodule
bind ddr_edc_path edc_path_checker edc_path_checker_i (
	.clock, .rst_n, .mem_iface_cfg, .mem_clock_speed_sel, .rd_valid, .err_fixed, .dq_oe_n,
	.dqs_out, .dqs_oe_n, .error_correction, .mem_clk_sel, .cfg_locked, .arrangement
);
`default_nettype wire

//--- sim/mem_model.sv
// Behavioural external memory behind the correction path
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	input  wire logic        clock,
	input  wire logic        mem_clk,
	input  wire logic        rd_req,
	input  wire logic [63:0] dq_out,
	input  wire logic        dq_oe_n,
	input  wire logic [63:0] flip,
	output logic      [63:0] dq_in,
	output logic      [3:0]  beats,
	output logic      [23:0] pad,
	output logic      [7:0]  depth
);
	logic [31:0] wb [$];
	logic [63:0] mq [$];
	logic [7:0]  cq [$];
	logic [31:0] rb [3] = '{default: 32'h0};
	logic [63:0] w;
	logic        go = 1'b0;
	logic        gone = 1'b0;
	int          ri = 9;
	int          idx;
	// Beats taken mid-cycle while the pins are driven, read beat index steps
	always @(negedge mem_clk) begin
		ri <= (go != gone) ? 1 : ri + 1;
		gone <= go;
		if (!dq_oe_n) begin
			wb.push_back(dq_out[31:0]);
		end
	end
	// Burst over: keep the word beside its check beat
	always @(posedge dq_oe_n) begin
		if (wb.size() > 1) begin
			beats <= 4'(wb.size());
			pad <= wb.size() > 2 ? wb[2][31:8] : 24'h0;
			mq.push_back({wb[1], wb[0]});
			cq.push_back(wb.size() > 2 ? wb[2][7:0] : 8'h00);
			wb.delete();
		end
	end
	// Read: oldest word, with commanded bit flips
	always @(posedge clock) begin
		if (rd_req && mq.size() > 0) begin
			w = mq.pop_front() ^ flip;
			rb[0] <= w[31:0];
			rb[1] <= w[63:32];
			rb[2] <= {24'h0, cq.pop_front()};
			go <= ~go;
		end
		depth <= 8'(mq.size());
	end
	// Beat index, zero from the read request until the next falling link edge
	assign idx = (go != gone) ? 0 : ri;
	// Released pins alternate around the last beat
	assign dq_in = {2{idx < 3 ? rb[idx] : (idx[0] ? ~rb[2] : rb[2])}};
endmodule
`default_nettype wire

//--- sim/ddr_edc_path_tb.sv
// Self-checking bench for the memory error correction path
`timescale 1ns/100ps
`default_nettype none
module ddr_edc_path_tb;
	typedef struct packed {
		logic [2:0] cfg;
		logic       edc;
		logic [1:0] arr;
	} row_t;
	// Code beside latched enable and arrangement
	row_t        rows [8] = '{'{3'h0, 1'h0, 2'h0}, '{3'h2, 1'h1, 2'h0}, '{3'h1, 1'h0, 2'h1},
		'{3'h3, 1'h1, 2'h1}, '{3'h7, 1'h0, 2'h3}, '{3'h5, 1'h1, 2'h3}, '{3'h4, 1'h0, 2'h2},
		'{3'h6, 1'h1, 2'h2}};
	logic        clock = 1'h0;
	logic        rst_n = 1'h0;
	logic        mem_clk = 1'h0;
	logic [2:0]  mem_iface_cfg = 3'h0;
	logic        mem_clock_speed_sel = 1'h0;
	logic [63:0] wr_data = 64'h0;
	logic        wr_valid = 1'h0;
	logic        rd_req = 1'h0;
	logic [63:0] flip = 64'h0;
	logic [63:0] dq_in;
	logic [63:0] dq_out;
	logic [63:0] rd_data;
	logic [7:0]  dqs_out;
	logic [7:0]  depth;
	logic [23:0] pad;
	logic [3:0]  beats;
	logic [1:0]  arrangement;
	logic        wr_ready, rd_valid, err_fixed, dq_oe_n, dqs_oe_n;
	logic        error_correction, mem_clk_sel, cfg_locked, full_seen;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;
	int          n;
	int          acc;
	ddr_edc_path ddr_edc_path_i (
		.clock, .rst_n, .mem_iface_cfg, .mem_clock_speed_sel, .mem_clk, .wr_data, .wr_valid,
		.wr_ready, .rd_req, .rd_data, .rd_valid, .err_fixed, .dq_in, .dq_out, .dq_oe_n,
		.dqs_out, .dqs_oe_n, .error_correction, .mem_clk_sel, .cfg_locked, .arrangement
	);
	mem_model mem_model_i (
		.clock, .mem_clk, .rd_req, .dq_out, .dq_oe_n, .flip, .dq_in, .beats, .pad, .depth
	);
	// System clock and a link clock of unrelated phase
	always #25 clock = ~clock;
	initial begin
		#13;
		forever #200 mem_clk = ~mem_clk;
	end
	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic [2:0] c, input logic s);
		mem_iface_cfg <= c;
		mem_clock_speed_sel <= s;
		rst_n <= 1'h0;
		repeat (3) @(posedge clock);
		cmp(64'({dq_oe_n, dqs_oe_n, wr_ready, cfg_locked, rd_valid}), 64'h1C);
		rst_n <= 1'h1;
		for (n = 0; n < 9 && cfg_locked !== 1'h1; n++) @(posedge clock);
	endtask
	task automatic write_word(input logic [63:0] w);
		wr_data <= w;
		wr_valid <= 1'h1;
		@(posedge clock);
		while (wr_ready !== 1'h1) @(posedge clock);
		wr_valid <= 1'h0;
		for (n = 0; n < 400 && depth !== 8'h01; n++) @(posedge clock);
	endtask
	task automatic read_word(input logic [63:0] exp, input logic fix);
		@(negedge mem_clk);
		@(posedge clock);
		rd_req <= 1'h1;
		@(posedge clock);
		rd_req <= 1'h0;
		for (n = 0; n < 40 && rd_valid !== 1'h1; n++) @(posedge clock);
		cmp(rd_data, exp);
		cmp(64'({rd_valid, err_fixed}), 64'({1'h1, fix}));
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		// Every code: decode, one stored word, read back
		foreach (rows[i]) begin
			do_reset(rows[i].cfg, i[0]);
			cmp(64'({error_correction, arrangement, mem_clk_sel}), 64'({rows[i].edc, rows[i].arr, i[0]}));
			write_word(64'h0123456789ABCDEF ^ 64'(i));
			cmp(64'({beats, pad}), 64'({rows[i].edc ? 4'h3 : 4'h2, 24'h0}));
			read_word(64'h0123456789ABCDEF ^ 64'(i), 1'h0);
		end
		// Single flips in both beats, then a double flip
		do_reset(3'h2, 1'h0);
		for (int k = 0; k < 4; k++) begin
			write_word(64'hFEDCBA9876543210);
			flip <= k == 3 ? 64'h3 : 64'h1 << (k * 31);
			read_word(64'hFEDCBA9876543210 ^ 64'(k / 3 * 3), k != 3);
		end
		flip <= 64'h0;
		// Back-to-back writes until refused, then drain all
		acc = 0;
		full_seen = 1'h0;
		wr_valid <= 1'h1;
		for (int k = 0; k < 60; k++) begin
			wr_data <= 64'hA5A5000000000000 + 64'(acc);
			@(posedge clock);
			if (wr_ready === 1'h1) acc++;
			else full_seen = 1'h1;
		end
		wr_valid <= 1'h0;
		cmp(64'(full_seen), 64'h1);
		for (n = 0; n < 2000 && depth !== 8'(acc); n++) @(posedge clock);
		for (int k = 0; k < acc; k++) read_word(64'hA5A5000000000000 + 64'(k), 1'h0);
		cmp(64'(wr_ready), 64'h1);
		finish_test();
	end
endmodule
`default_nettype wire
